// [rpb_defines.svh]
// Constants for the ROM patch block that serves substitution banks four and five.
// Assumes a 50 MHz aclk and a 32-bit AXI4-Lite slave port with 16-bit byte addresses.
// What this block does
// - Low compare register holds address bits 7..1
// - Middle compare register holds address bits 15..8
// - High compare register holds address bits 23..16
// - Low patch register holds patch bits 7..0
// - High patch register holds patch bits 15..8
// - Compare bit 0 reads as zero, unused
// - Match blocks ROM read, drives patch word
`ifndef RPB_DEFINES_SVH
`define RPB_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define RPB_IDX_B4_ADDR_LOW 12'h420
`define RPB_IDX_B4_ADDR_MID 12'h421
`define RPB_IDX_B4_ADDR_HIGH 12'h422
`define RPB_IDX_B4_WORD_LOW 12'h424
`define RPB_IDX_B4_WORD_HIGH 12'h425
`define RPB_IDX_B5_ADDR_LOW 12'h428
`define RPB_IDX_B5_ADDR_MID 12'h429
`define RPB_IDX_B5_ADDR_HIGH 12'h42a
`define RPB_IDX_B5_WORD_LOW 12'h42c
`define RPB_IDX_B5_WORD_HIGH 12'h42d
`define RPB_IDX_STATUS 12'h430

// Reset value of every patch register byte.
`define RPB_REG_RESET 8'h00

// Field positions inside the status word.
`define RPB_STAT_HIT_LSB 0
`define RPB_STAT_HIT_MSB 1
`define RPB_STAT_CNT_LSB 8
`define RPB_STAT_CNT_MSB 15

// AXI response codes.
`define RPB_RESP_OKAY 2'b00
`define RPB_RESP_SLVERR 2'b10

`endif

// [rpb_pkg.sv]
// Types shared by the ROM patch block and its helpers.
// Assumes rpb_defines.svh is compiled into the same build.
package rpb_pkg;

  // Register selected by an address; for bank registers bit 3 picks bank five, bits 2:0 the field.
  typedef enum logic [3:0] {
    SEL_NONE = 4'b0000,
    SEL_B4_ADDR_LOW = 4'b0001,
    SEL_B4_ADDR_MID = 4'b0010,
    SEL_B4_ADDR_HIGH = 4'b0011,
    SEL_B4_WORD_LOW = 4'b0100,
    SEL_B4_WORD_HIGH = 4'b0101,
    SEL_B5_ADDR_LOW = 4'b1001,
    SEL_B5_ADDR_MID = 4'b1010,
    SEL_B5_ADDR_HIGH = 4'b1011,
    SEL_B5_WORD_LOW = 4'b1100,
    SEL_B5_WORD_HIGH = 4'b1101,
    SEL_STATUS = 4'b1110
  } rpb_sel_e;

  // One substitution bank: target address bits 23..1 and the two patch bytes.
  typedef struct packed {
    logic [23:1] target;
    logic [7:0] word_high;
    logic [7:0] word_low;
  } rpb_bank_s;

  // AXI4-Lite signals driven by the master.
  typedef struct packed {
    logic awvalid;
    logic [15:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [15:0] araddr;
    logic rready;
  } rpb_axil_req_s;

  // AXI4-Lite signals driven by this slave.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rpb_axil_rsp_s;

  // Instruction fetch request from the processor core.
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
  } rpb_fetch_req_s;

  // Answer to a fetch: ROM strobe or the patch word on the internal bus.
  typedef struct packed {
    logic rom_rd_strobe;
    logic patch_drive;
    logic [15:0] patch_word;
    logic [7:0] patch_byte;
  } rpb_fetch_rsp_s;

endpackage

// [rpb_reg_decode.sv]
// Address decoder that maps an AXI byte address onto a patch register.
// Assumes word-aligned accesses; any other address selects nothing.
`include "rpb_defines.svh"

module rpb_reg_decode (
  // Byte address from the bus.
  input wire logic [15:0] byte_addr,
  // Selected register.
  output rpb_pkg::rpb_sel_e sel
);

  // Tells whether the address is the aligned word of a register index.
  function automatic logic at_index(input logic [15:0] a, input logic [11:0] idx);
    at_index = (a == {2'b00, idx, 2'b00});
  endfunction

  // Unmapped and misaligned addresses fall through to no selection.
  always_comb begin
    sel = rpb_pkg::SEL_NONE;
    if (at_index(byte_addr, `RPB_IDX_B4_ADDR_LOW)) sel = rpb_pkg::SEL_B4_ADDR_LOW;
    if (at_index(byte_addr, `RPB_IDX_B4_ADDR_MID)) sel = rpb_pkg::SEL_B4_ADDR_MID;
    if (at_index(byte_addr, `RPB_IDX_B4_ADDR_HIGH)) sel = rpb_pkg::SEL_B4_ADDR_HIGH;
    if (at_index(byte_addr, `RPB_IDX_B4_WORD_LOW)) sel = rpb_pkg::SEL_B4_WORD_LOW;
    if (at_index(byte_addr, `RPB_IDX_B4_WORD_HIGH)) sel = rpb_pkg::SEL_B4_WORD_HIGH;
    if (at_index(byte_addr, `RPB_IDX_B5_ADDR_LOW)) sel = rpb_pkg::SEL_B5_ADDR_LOW;
    if (at_index(byte_addr, `RPB_IDX_B5_ADDR_MID)) sel = rpb_pkg::SEL_B5_ADDR_MID;
    if (at_index(byte_addr, `RPB_IDX_B5_ADDR_HIGH)) sel = rpb_pkg::SEL_B5_ADDR_HIGH;
    if (at_index(byte_addr, `RPB_IDX_B5_WORD_LOW)) sel = rpb_pkg::SEL_B5_WORD_LOW;
    if (at_index(byte_addr, `RPB_IDX_B5_WORD_HIGH)) sel = rpb_pkg::SEL_B5_WORD_HIGH;
    if (at_index(byte_addr, `RPB_IDX_STATUS)) sel = rpb_pkg::SEL_STATUS;
  end

endmodule

// [rpb_bank_match.sv]
// Address comparator for one substitution bank.
// Assumes the target is held in registers and the fetch address is synchronous.
module rpb_bank_match (
  // Stored bank contents.
  input rpb_pkg::rpb_bank_s bank,
  // Fetch address from the core.
  input wire logic [23:0] fetch_addr,
  // High while the fetch falls inside the bank's two-byte location.
  output logic hit
);

  // Address bit 0 takes no part, so one bank covers the even byte and the odd byte.
  always_comb begin
    hit = (fetch_addr[23:1] == bank.target);
  end

endmodule

// [rpb_rom_patch.sv]
// Top of the ROM patch block: two substitution banks behind an AXI4-Lite slave.
// Assumes one 50 MHz clock, a synchronous active-low reset and a core whose fetch
// request is synchronous to aclk and takes its answer one cycle later.
//
// Design decision made here: the AXI4-Lite register port.
`include "rpb_defines.svh"

module rpb_rom_patch (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input rpb_pkg::rpb_axil_req_s axil_req,
  output rpb_pkg::rpb_axil_rsp_s axil_rsp,
  // Fetch path from the core and towards the ROM and internal bus.
  input rpb_pkg::rpb_fetch_req_s fetch_req,
  output rpb_pkg::rpb_fetch_rsp_s fetch_rsp
);

  // Whole state of the block in one packed word.
  typedef struct packed {
    rpb_pkg::rpb_axil_rsp_s rsp; // Bus outputs, kept in flops.
    logic [15:0] aw_addr; // Captured write address.
    logic [31:0] wdata; // Captured write data.
    logic [3:0] wstrb; // Captured byte enables.
    rpb_pkg::rpb_bank_s [1:0] bank; // Index 0 is bank four, 1 is bank five.
    rpb_pkg::rpb_fetch_rsp_s fetch; // Fetch answer, kept in flops.
    logic [1:0] last_hit; // Bank that answered the latest patched fetch.
    logic [7:0] hit_count; // Patched fetches seen, wrapping.
  } rpb_state_s;

  rpb_state_s st_reg; // Registered state.
  rpb_state_s st_next; // Next state.
  rpb_pkg::rpb_sel_e wsel; // Register hit by the held write address.
  rpb_pkg::rpb_sel_e rsel; // Register hit by the offered read address.
  logic hit4; // Fetch address matches bank four.
  logic hit5; // Fetch address matches bank five.
  logic wr_go; // Address and data both held and no response pending.

  // Write-side decoder works on the captured address.
  rpb_reg_decode u_wdec (
    .byte_addr(st_reg.aw_addr),
    .sel(wsel)
  );

  // Read-side decoder works on the live address, taken in the handshake cycle.
  rpb_reg_decode u_rdec (
    .byte_addr(axil_req.araddr),
    .sel(rsel)
  );

  // Comparators for both banks.
  rpb_bank_match u_match4 (
    .bank(st_reg.bank[0]),
    .fetch_addr(fetch_req.addr),
    .hit(hit4)
  );

  rpb_bank_match u_match5 (
    .bank(st_reg.bank[1]),
    .fetch_addr(fetch_req.addr),
    .hit(hit5)
  );

  // Stores one byte into the field that the selector names.
  function automatic rpb_pkg::rpb_bank_s bank_write(input rpb_pkg::rpb_bank_s b,
                                                    input logic [2:0] field,
                                                    input logic [7:0] d);
    rpb_pkg::rpb_bank_s nb;
    nb = b;
    case (field)
      3'b001: nb.target[7:1] = d[7:1];
      3'b010: nb.target[15:8] = d;
      3'b011: nb.target[23:16] = d;
      3'b100: nb.word_low = d;
      3'b101: nb.word_high = d;
      default: nb = b;
    endcase
    bank_write = nb;
  endfunction

  // The held write goes ahead once both channels have been taken.
  always_comb begin
    wr_go = !st_reg.rsp.awready && !st_reg.rsp.wready && !st_reg.rsp.bvalid;
  end

  // Next-state logic for the bus slave, the banks and the fetch answer.
  always_comb begin
    st_next = st_reg;
    // Address and data are taken independently, in either order.
    if (axil_req.awvalid && st_reg.rsp.awready) begin
      st_next.aw_addr = axil_req.awaddr;
      st_next.rsp.awready = 1'b0;
    end
    if (axil_req.wvalid && st_reg.rsp.wready) begin
      st_next.wdata = axil_req.wdata;
      st_next.wstrb = axil_req.wstrb;
      st_next.rsp.wready = 1'b0;
    end
    // Bank registers are write-only, so software has no stored value to merge into a write.
    if (wr_go) begin
      if (wsel != rpb_pkg::SEL_NONE && wsel != rpb_pkg::SEL_STATUS && st_reg.wstrb[0]) begin
        st_next.bank[wsel[3]] = bank_write(st_reg.bank[wsel[3]], wsel[2:0], st_reg.wdata[7:0]);
      end
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp = (wsel == rpb_pkg::SEL_NONE) ? `RPB_RESP_SLVERR : `RPB_RESP_OKAY;
    end
    // Response taken: both write channels reopen together.
    if (st_reg.rsp.bvalid && axil_req.bready) begin
      st_next.rsp.bvalid = 1'b0;
      st_next.rsp.awready = 1'b1;
      st_next.rsp.wready = 1'b1;
    end
    // Reads answer one cycle after the address is taken.
    if (axil_req.arvalid && st_reg.rsp.arready) begin
      st_next.rsp.arready = 1'b0;
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rresp = `RPB_RESP_OKAY;
      // Bank registers cannot return what they hold; bit 0 included, they read as zero.
      st_next.rsp.rdata = 32'h0000_0000;
      if (rsel == rpb_pkg::SEL_NONE) begin
        st_next.rsp.rresp = `RPB_RESP_SLVERR;
      end else if (rsel == rpb_pkg::SEL_STATUS) begin
        st_next.rsp.rdata[`RPB_STAT_HIT_MSB:`RPB_STAT_HIT_LSB] = st_reg.last_hit;
        st_next.rsp.rdata[`RPB_STAT_CNT_MSB:`RPB_STAT_CNT_LSB] = st_reg.hit_count;
      end
    end
    if (st_reg.rsp.rvalid && axil_req.rready) begin
      st_next.rsp.rvalid = 1'b0;
      st_next.rsp.arready = 1'b1;
    end
    // Fetch answer: a match withholds the ROM strobe and puts the patch on the bus.
    // Bank four wins when both banks hold the same target.
    st_next.fetch.rom_rd_strobe = 1'b0;
    st_next.fetch.patch_drive = 1'b0;
    st_next.fetch.patch_word = 16'h0000;
    st_next.fetch.patch_byte = 8'h00;
    if (fetch_req.valid) begin
      if (hit4 || hit5) begin
        st_next.fetch.patch_drive = 1'b1;
        st_next.fetch.patch_word = hit4 ? {st_reg.bank[0].word_high, st_reg.bank[0].word_low}
                                        : {st_reg.bank[1].word_high, st_reg.bank[1].word_low};
        // Odd address takes the high byte, even the low byte.
        st_next.fetch.patch_byte = fetch_req.addr[0] ? st_next.fetch.patch_word[15:8]
                                                     : st_next.fetch.patch_word[7:0];
        st_next.last_hit = {!hit4 && hit5, hit4};
        st_next.hit_count = st_reg.hit_count + 8'h01;
      end else begin
        st_next.fetch.rom_rd_strobe = 1'b1;
      end
    end
  end

  // State register; reset zeroes the banks and opens every request channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Zero covers every bank byte, whose reset value is all zeros.
      st_reg <= '0;
      st_reg.rsp.awready <= 1'b1;
      st_reg.rsp.wready <= 1'b1;
      st_reg.rsp.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state flops.
  always_comb begin
    axil_rsp = st_reg.rsp;
    fetch_rsp = st_reg.fetch;
  end

  // A write to the low compare register of bank four stores bits 7..1 only.
  AST_ADDR_LOW_FIELD: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wsel == rpb_pkg::SEL_B4_ADDR_LOW && st_reg.wstrb[0]
    |=> st_reg.bank[0].target[7:1] == $past(st_reg.wdata[7:1])
        && $stable(st_reg.bank[0].target[23:8]))
    else $error("Bank four low compare field not stored.");

  // A write to the middle compare register of bank five stores bits 15..8.
  AST_ADDR_MID_FIELD: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wsel == rpb_pkg::SEL_B5_ADDR_MID && st_reg.wstrb[0]
    |=> st_reg.bank[1].target[15:8] == $past(st_reg.wdata[7:0]))
    else $error("Bank five middle compare field not stored.");

  // A write to the high compare register of bank four stores bits 23..16.
  AST_ADDR_HIGH_FIELD: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wsel == rpb_pkg::SEL_B4_ADDR_HIGH && st_reg.wstrb[0]
    |=> st_reg.bank[0].target[23:16] == $past(st_reg.wdata[7:0]) && $stable(st_reg.bank[1]))
    else $error("Bank four high compare field not stored.");

  // A low patch write lands in the low byte and leaves the high byte alone.
  AST_WORD_LOW_FIELD: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wsel == rpb_pkg::SEL_B5_WORD_LOW && st_reg.wstrb[0]
    |=> st_reg.bank[1].word_low == $past(st_reg.wdata[7:0]) && $stable(st_reg.bank[1].word_high))
    else $error("Bank five low patch byte not stored.");

  // A high patch write lands in the high byte.
  AST_WORD_HIGH_FIELD: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && wsel == rpb_pkg::SEL_B4_WORD_HIGH && st_reg.wstrb[0]
    |=> st_reg.bank[0].word_high == $past(st_reg.wdata[7:0]) && $stable(st_reg.bank[0].word_low))
    else $error("Bank four high patch byte not stored.");

  // Bank registers never give back their contents on a read.
  AST_READ_WRITE_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    axil_req.arvalid && axil_rsp.arready && rsel != rpb_pkg::SEL_NONE && rsel != rpb_pkg::SEL_STATUS
    |=> axil_rsp.rvalid && axil_rsp.rdata == 32'h0000_0000 && axil_rsp.rresp == `RPB_RESP_OKAY)
    else $error("Write-only register returned data.");

  // A bank-four match blocks the ROM strobe and drives bank four's word next cycle.
  AST_HIT_SUBSTITUTES: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_req.valid && hit4
    |=> !fetch_rsp.rom_rd_strobe && fetch_rsp.patch_drive
        && fetch_rsp.patch_word == {$past(st_reg.bank[0].word_high), $past(st_reg.bank[0].word_low)})
    else $error("Matched fetch not substituted.");

  // A fetch that matches no bank reads the ROM and leaves the bus alone.
  AST_MISS_READS_ROM: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_req.valid && !hit4 && !hit5 |=> fetch_rsp.rom_rd_strobe && !fetch_rsp.patch_drive)
    else $error("Unmatched fetch did not strobe the ROM.");

  // An odd fetch address inside a matched location gets the high patch byte.
  AST_ODD_BYTE_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_req.valid && fetch_req.addr[0] && !hit4 && hit5
    |=> fetch_rsp.patch_byte == $past(st_reg.bank[1].word_high))
    else $error("Odd byte not taken from the high patch byte.");

  // Once address and data are both held, the response follows in one cycle.
  AST_WRITE_RESPONSE: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> axil_rsp.bvalid)
    else $error("Write response missing after both channels taken.");

endmodule

// [rpb_core_model.sv]
// Behavioural processor core that fetches through the patch block, with a small ROM image.
// Assumes the block answers each fetch exactly one cycle after the edge that takes it.
module rpb_core_model (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bench command: start one fetch at go_addr.
  input wire logic go,
  input wire logic [23:0] go_addr,
  // Fetch interface towards the block.
  output rpb_pkg::rpb_fetch_req_s fetch_req,
  input rpb_pkg::rpb_fetch_rsp_s fetch_rsp,
  // What the core finally read.
  output logic [7:0] got_byte,
  output logic [15:0] got_word,
  output logic got_rom
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pend_reg; // A request is waiting for its answer.
  logic [23:0] adr_reg; // Address of the request in flight.

  // Issue one-cycle requests and collect answers a cycle later.
  // An idle address bus inverts itself on every cycle, so a stale address never stays put on it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_req <= '0;
      pend_reg <= 1'b0;
      got_rom <= 1'b0;
      got_byte <= 8'h00;
      got_word <= 16'h0000;
    end else begin
      fetch_req.valid <= go;
      fetch_req.addr <= go ? go_addr : ~fetch_req.addr;
      pend_reg <= fetch_req.valid;
      if (fetch_req.valid) begin
        adr_reg <= fetch_req.addr;
      end
      if (pend_reg) begin
        // With the ROM strobe held off, the byte comes from the internal bus instead.
        got_rom <= fetch_rsp.rom_rd_strobe;
        got_byte <= fetch_rsp.rom_rd_strobe ? (adr_reg[7:0] ^ 8'h5a) : fetch_rsp.patch_byte;
        got_word <= fetch_rsp.patch_word;
      end
    end
  end
endmodule

// [rpb_tb.sv]
// Self-checking bench for the ROM patch block: AXI4-Lite master tasks and a fetching core.
// Assumes the core model's ROM image is the fetch address low byte XOR 0x5a.
`include "rpb_defines.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk = 1'b0; // 50 MHz system clock.
  logic aresetn = 1'b0; // Synchronous reset, active low.
  rpb_pkg::rpb_axil_req_s req = '0; // Master side of the bus.
  rpb_pkg::rpb_axil_rsp_s rsp; // Slave answer.
  rpb_pkg::rpb_axil_rsp_s rs; // Answer sampled away from the edge, free of races.
  rpb_pkg::rpb_fetch_req_s freq;
  rpb_pkg::rpb_fetch_rsp_s frsp;
  logic go = 1'b0;
  logic [23:0] go_addr = 24'h00_0000;
  logic [7:0] got_byte;
  logic [15:0] got_word;
  logic got_rom;
  int failures = 0;
  int n_checks = 0;

  always #10 aclk = ~aclk;
  // Flop outputs only move at rising edges, so the falling-edge copy is what the next edge sees.
  always @(negedge aclk) rs <= rsp;

  rpb_rom_patch uut (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
    .fetch_req(freq), .fetch_rsp(frsp));
  rpb_core_model core (.aclk(aclk), .aresetn(aresetn), .go(go), .go_addr(go_addr),
    .fetch_req(freq), .fetch_rsp(frsp), .got_byte(got_byte), .got_word(got_word), .got_rom(got_rom));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Byte address of a register index.
  function automatic logic [15:0] ba(input logic [11:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  // One write; address and data stay up until each is taken, bready until the response.
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
    int t = 0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h00_0000, d};
    req.wstrb <= s;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (rs.awready) req.awvalid <= 1'b0;
      if (rs.wready) req.wvalid <= 1'b0;
    end while (rs.bvalid !== 1'b1 && t < 50);
    req.bready <= 1'b0;
    check(rs.bresp, er);
    // Let one edge pass so the next write never re-raises bready in this time step.
    @(posedge aclk);
  endtask

  // One read; the data and response are taken at the edge that sees rvalid.
  task automatic rd(input logic [15:0] a, input logic [1:0] er, input logic [31:0] ed = 32'h0000_0000);
    int t = 0;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
      if (rs.arready) req.arvalid <= 1'b0;
    end while (rs.rvalid !== 1'b1 && t < 50);
    req.rready <= 1'b0;
    check(rs.rresp, er);
    check(rs.rdata, ed);
    // Let one edge pass so the next read never re-raises rready in this time step.
    @(posedge aclk);
  endtask

  // Program a bank with plain writes only, never read-modify-write.
  task automatic prog(input logic [11:0] b, input logic [23:0] t, input logic [15:0] w);
    wr(ba(b), t[7:0], 4'hf, `RPB_RESP_OKAY);
    wr(ba(b + 12'h001), t[15:8], 4'hf, `RPB_RESP_OKAY);
    wr(ba(b + 12'h002), t[23:16], 4'hf, `RPB_RESP_OKAY);
    wr(ba(b + 12'h004), w[7:0], 4'hf, `RPB_RESP_OKAY);
    wr(ba(b + 12'h005), w[15:8], 4'hf, `RPB_RESP_OKAY);
  endtask

  // One fetch; the core sees its answer a fixed three edges after the command.
  task automatic fx(input logic [23:0] a, input logic er, input logic [7:0] eb);
    go <= 1'b1;
    go_addr <= a;
    @(posedge aclk);
    go <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check(got_rom, er);
    check(got_byte, er ? (a[7:0] ^ 8'h5a) : eb);
    @(posedge aclk);
  endtask

  // After reset every bank register reads zero and the zeroed banks cover address zero.
  task automatic t_reset;
    for (int i = 0; i < 14; i++) begin
      if (i != 3 && i != 6 && i != 7 && i != 11) rd(ba(`RPB_IDX_B4_ADDR_LOW + i[11:0]), `RPB_RESP_OKAY);
    end
    fx(24'h00_0000, 1'b0, 8'h00);
    $display("test reset done");
  endtask

  // Bank four with bit 0 of the target set; every other single-bit miss reads the ROM.
  task automatic t_bank4;
    prog(`RPB_IDX_B4_ADDR_LOW, 24'hFF_1235, 16'hDDCC);
    fx(24'hFF_1234, 1'b0, 8'hCC);
    fx(24'hFF_1235, 1'b0, 8'hDD);
    check(got_word, 32'h0000_DDCC);
    for (int i = 1; i < 24; i++) fx(24'hFF_1234 ^ (24'h00_0001 << i), 1'b1, 8'h00);
    $display("test bank4 done");
  endtask

  // Two banks side by side cover an odd-start pair; bank four wins an overlap.
  task automatic t_bank5;
    prog(`RPB_IDX_B4_ADDR_LOW, 24'hFF_1236, 16'hEE66);
    prog(`RPB_IDX_B5_ADDR_LOW, 24'hFF_1238, 16'h99FF);
    fx(24'hFF_1237, 1'b0, 8'hEE);
    fx(24'hFF_1238, 1'b0, 8'hFF);
    fx(24'hFF_1239, 1'b0, 8'h99);
    fx(24'hFF_123A, 1'b1, 8'h00);
    prog(`RPB_IDX_B5_ADDR_LOW, 24'hFF_1236, 16'h1111);
    fx(24'hFF_1236, 1'b0, 8'h66);
    // Seven patched fetches so far, the latest answered by bank four.
    rd(ba(`RPB_IDX_STATUS), `RPB_RESP_OKAY, 32'h0000_0701);
    $display("test bank5 done");
  endtask

  // Refused accesses and a write with no byte enables leave the banks alone.
  task automatic t_errors;
    wr(16'h108C, 8'h77, 4'hf, `RPB_RESP_SLVERR);
    rd(16'h108C, `RPB_RESP_SLVERR);
    wr(ba(`RPB_IDX_B4_WORD_LOW) + 16'h0001, 8'h77, 4'hf, `RPB_RESP_SLVERR);
    wr(ba(`RPB_IDX_B4_WORD_LOW), 8'h77, 4'h0, `RPB_RESP_OKAY);
    fx(24'hFF_1236, 1'b0, 8'h66);
    $display("test errors done");
  endtask

  // A reset in mid-run clears every bank back to zero.
  task automatic t_rereset;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    fx(24'hFF_1236, 1'b1, 8'h00);
    fx(24'h00_0001, 1'b0, 8'h00);
    $display("test rereset done");
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_bank4();
    t_bank5();
    t_errors();
    t_rereset();
    wrap_up();
  end

  // The tests need well under 2000 cycles; a hang is cut off long after that.
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    wrap_up();
  end
endmodule
